// >>> hw/dspg_pkg.sv
`default_nettype none
package dspg_pkg;

  // ==========================================================
  // bus geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int PORTS = 8;

  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [ADDR_W-1:0] OFS_RUN_CFG = 12'h060;
  localparam logic [ADDR_W-1:0] OFS_RUN_GATE = 12'h108;
  localparam logic [ADDR_W-1:0] OFS_SLEEP_GATE = 12'h118;
  localparam logic [ADDR_W-1:0] OFS_DEEP_GATE = 12'h128;
  localparam logic [ADDR_W-1:0] OFS_INT_STATUS = 12'h140;
  localparam logic [ADDR_W-1:0] OFS_INT_MASK = 12'h144;
  localparam logic [ADDR_W-1:0] OFS_CLK_STATE = 12'h148;

  // ==========================================================
  // field layout and reset values
  localparam int GATE_LSB = 0;
  localparam int ACG_BIT = 0;
  localparam int MODE_LSB = 8;
  localparam logic [PORTS-1:0] GATE_RESET = 8'h00;
  localparam logic [DATA_W-1:0] WORD_ZERO = 32'h00000000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // types
  typedef enum logic [1:0] {
    MODE_RUN,
    MODE_SLEEP,
    MODE_DEEP
  } dspg_mode_t;

  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_CFG,
    SEL_RUN,
    SEL_SLEEP,
    SEL_DEEP,
    SEL_STATUS,
    SEL_MASK,
    SEL_STATE
  } dspg_sel_t;

endpackage
`default_nettype wire

// >>> hw/dspg_port_guard.sv
`timescale 1ns/1ps
`default_nettype none
module dspg_port_guard
  import dspg_pkg::*;
#(
  parameter int NPORT = PORTS
)
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // gating state
  input wire logic [NPORT-1:0] clk_en,
  // port access request
  input wire logic acc_valid,
  input wire logic [$clog2(NPORT)-1:0] acc_port,
  // answer
  output logic acc_done,
  output logic acc_fault,
  output logic [NPORT-1:0] fault_event
);

  // ==========================================================
  // access check
  logic hit_gated;

  assign hit_gated = acc_valid && !clk_en[acc_port];

  // answer one cycle after the request, fault if the clock is off
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      acc_done <= 1'b0;
      acc_fault <= 1'b0;
    end
    else
    begin
      acc_done <= acc_valid;
      acc_fault <= hit_gated;
    end
  end

  // one-hot event for the interrupt status
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      fault_event <= '0;
    end
    else
    begin
      fault_event <= '0;
      if (hit_gated)
      begin
        fault_event[acc_port] <= 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// >>> hw/dspg_top.sv
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module dspg_top
  import dspg_pkg::*;
#(
  parameter int NPORT = PORTS
)
(
  // clock and reset
  input wire logic CLK,
  input wire logic SRST,
  // axi4-lite write address
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic [2:0] S_AXI_AWPROT,
  // axi4-lite write data
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  input wire logic [DATA_W-1:0] S_AXI_WDATA,
  input wire logic [DATA_W/8-1:0] S_AXI_WSTRB,
  // axi4-lite write response
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  output logic [1:0] S_AXI_BRESP,
  // axi4-lite read address
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic [2:0] S_AXI_ARPROT,
  // axi4-lite read data
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic [DATA_W-1:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  // power mode from the system controller
  input wire logic SLEEP_MODE,
  input wire logic DEEP_SLEEP_MODE,
  // port clock enables
  output logic [NPORT-1:0] PORT_CLK_EN,
  // port access fault check
  input wire logic PORT_ACC_VALID,
  input wire logic [$clog2(NPORT)-1:0] PORT_ACC_PORT,
  output logic PORT_ACC_DONE,
  output logic PORT_ACC_FAULT,
  // interrupt
  output logic IRQ
);

  // ==========================================================
  // address decode
  function automatic dspg_sel_t reg_sel(input logic [ADDR_W-1:0] addr);
    dspg_sel_t sel;
    sel = SEL_NONE;
    unique case (addr)
      OFS_RUN_CFG: sel = SEL_CFG;
      OFS_RUN_GATE: sel = SEL_RUN;
      OFS_SLEEP_GATE: sel = SEL_SLEEP;
      OFS_DEEP_GATE: sel = SEL_DEEP;
      OFS_INT_STATUS: sel = SEL_STATUS;
      OFS_INT_MASK: sel = SEL_MASK;
      OFS_CLK_STATE: sel = SEL_STATE;
      default: sel = SEL_NONE;
    endcase
    return sel;
  endfunction

  // ==========================================================
  // declarations
  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [DATA_W-1:0] w_data;
  logic w_lane0;
  logic aw_fire;
  logic w_fire;
  logic wr_do;
  logic ar_fire;
  logic next_aw_held;
  logic next_w_held;
  dspg_sel_t wr_sel;
  dspg_sel_t rd_sel;

  logic auto_gate;
  logic [NPORT-1:0] run_gate;
  logic [NPORT-1:0] sleep_gate;
  logic [NPORT-1:0] deep_gate;
  logic [NPORT-1:0] int_status;
  logic [NPORT-1:0] int_mask;
  dspg_mode_t mode;
  logic [NPORT-1:0] next_clk_en;
  logic [NPORT-1:0] fault_event;
  logic [DATA_W-1:0] rd_word;

  assign aw_fire = S_AXI_AWVALID && S_AXI_AWREADY;
  assign w_fire = S_AXI_WVALID && S_AXI_WREADY;
  assign ar_fire = S_AXI_ARVALID && S_AXI_ARREADY;
  assign wr_do = aw_held && w_held && !S_AXI_BVALID;
  assign wr_sel = reg_sel(aw_addr);
  assign rd_sel = reg_sel(S_AXI_ARADDR);

  // ==========================================================
  // write channels: address and data taken in either order
  always_comb
  begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    if (aw_fire)
    begin
      next_aw_held = 1'b1;
    end
    else if (wr_do)
    begin
      next_aw_held = 1'b0;
    end
    if (w_fire)
    begin
      next_w_held = 1'b1;
    end
    else if (wr_do)
    begin
      next_w_held = 1'b0;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY <= 1'b0;
    end
    else
    begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      S_AXI_AWREADY <= !next_aw_held;
      S_AXI_WREADY <= !next_w_held;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      aw_addr <= '0;
      w_data <= WORD_ZERO;
      w_lane0 <= 1'b0;
    end
    else
    begin
      if (aw_fire)
      begin
        aw_addr <= S_AXI_AWADDR;
      end
      if (w_fire)
      begin
        w_data <= S_AXI_WDATA;
        w_lane0 <= S_AXI_WSTRB[0];
      end
    end
  end

  // write response, slverr for an unmapped address
  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= RESP_OKAY;
    end
    else if (wr_do)
    begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end
    else if (S_AXI_BREADY)
    begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  // ==========================================================
  // gating registers, one layout for all three modes
  // all enables only live in byte lane 0; upper lanes hold reserved bits
  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      run_gate <= GATE_RESET;
      sleep_gate <= GATE_RESET;
      deep_gate <= GATE_RESET;
      auto_gate <= 1'b0;
      int_mask <= '0;
    end
    else if (wr_do && w_lane0)
    begin
      unique case (wr_sel)
        SEL_RUN: run_gate <= w_data[GATE_LSB +: NPORT];
        SEL_SLEEP: sleep_gate <= w_data[GATE_LSB +: NPORT];
        SEL_DEEP: deep_gate <= w_data[GATE_LSB +: NPORT];
        SEL_CFG: auto_gate <= w_data[ACG_BIT];
        SEL_MASK: int_mask <= w_data[GATE_LSB +: NPORT];
        default:
        begin
        end
      endcase
    end
  end

  // ==========================================================
  // mode selection and port clock enables
  always_comb
  begin
    mode = MODE_RUN;
    if (auto_gate && DEEP_SLEEP_MODE)
    begin
      mode = MODE_DEEP;
    end
    else if (auto_gate && SLEEP_MODE)
    begin
      mode = MODE_SLEEP;
    end
  end

  // run register governs unless auto gating picks a sleep mode
  always_comb
  begin
    unique case (mode)
      MODE_DEEP: next_clk_en = deep_gate;
      MODE_SLEEP: next_clk_en = sleep_gate;
      default: next_clk_en = run_gate;
    endcase
  end

  // enables lag the register by one cycle so the output stays glitch-free
  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      PORT_CLK_EN <= GATE_RESET;
    end
    else
    begin
      PORT_CLK_EN <= next_clk_en;
    end
  end

  // ==========================================================
  // access check against the enables actually in force
  dspg_port_guard #(
    .NPORT(NPORT)
  ) u_guard (
    .clk(CLK),
    .srst(SRST),
    .clk_en(PORT_CLK_EN),
    .acc_valid(PORT_ACC_VALID),
    .acc_port(PORT_ACC_PORT),
    .acc_done(PORT_ACC_DONE),
    .acc_fault(PORT_ACC_FAULT),
    .fault_event(fault_event)
  );

  // ==========================================================
  // interrupt status: sticky, cleared by a read, a new event wins
  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      int_status <= '0;
    end
    else if (ar_fire && rd_sel == SEL_STATUS)
    begin
      int_status <= fault_event;
    end
    else
    begin
      int_status <= int_status | fault_event;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      IRQ <= 1'b0;
    end
    else
    begin
      IRQ <= |(int_status & int_mask);
    end
  end

  // ==========================================================
  // read path
  always_comb
  begin
    rd_word = WORD_ZERO;
    unique case (rd_sel)
      SEL_CFG: rd_word[ACG_BIT] = auto_gate;
      SEL_RUN: rd_word[GATE_LSB +: NPORT] = run_gate;
      SEL_SLEEP: rd_word[GATE_LSB +: NPORT] = sleep_gate;
      SEL_DEEP: rd_word[GATE_LSB +: NPORT] = deep_gate;
      SEL_STATUS: rd_word[GATE_LSB +: NPORT] = int_status;
      SEL_MASK: rd_word[GATE_LSB +: NPORT] = int_mask;
      SEL_STATE:
      begin
        rd_word[GATE_LSB +: NPORT] = PORT_CLK_EN;
        rd_word[MODE_LSB +: 2] = mode;
      end
      default: rd_word = WORD_ZERO;
    endcase
  end

  // one read under way; the address is taken only while no data waits
  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= WORD_ZERO;
      S_AXI_RRESP <= RESP_OKAY;
    end
    else if (ar_fire)
    begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA <= rd_word;
      S_AXI_RRESP <= (rd_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end
    else if (S_AXI_RVALID)
    begin
      if (S_AXI_RREADY)
      begin
        S_AXI_RVALID <= 1'b0;
        S_AXI_ARREADY <= 1'b1;
      end
    end
    else
    begin
      S_AXI_ARREADY <= 1'b1;
    end
  end

endmodule
`default_nettype wire

// >>> dv/dspg_top_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module dspg_top_assertions
  import dspg_pkg::*;
#(
  parameter int NPORT = PORTS
)
(
  // watched top ports
  input wire logic CLK,
  input wire logic SRST,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [DATA_W-1:0] S_AXI_RDATA,
  input wire logic SLEEP_MODE,
  input wire logic DEEP_SLEEP_MODE,
  input wire logic [NPORT-1:0] PORT_CLK_EN,
  input wire logic PORT_ACC_VALID,
  input wire logic [$clog2(NPORT)-1:0] PORT_ACC_PORT,
  input wire logic PORT_ACC_DONE,
  input wire logic PORT_ACC_FAULT,
  input wire logic IRQ
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);
  // ====================
  // access sequences
  sequence acc_gated;
    PORT_ACC_VALID && !PORT_CLK_EN[PORT_ACC_PORT];
  endsequence
  sequence acc_open;
    PORT_ACC_VALID && PORT_CLK_EN[PORT_ACC_PORT];
  endsequence
  // ====================
  // assertions
  reset_clear_a: assert property ($fell(SRST) |-> !(|PORT_CLK_EN) && !IRQ)
    else $error("outputs not clear after reset");
  gated_fault_a: assert property (acc_gated |=> PORT_ACC_DONE && PORT_ACC_FAULT)
    else $error("gated access not faulted");
  open_access_a: assert property (acc_open |=> PORT_ACC_DONE && !PORT_ACC_FAULT)
    else $error("clocked access faulted");
  done_cause_a: assert property (PORT_ACC_DONE |-> $past(PORT_ACC_VALID))
    else $error("answer without access");
  // a mode change shows one cycle late, so look two samples back
  enable_cause_a: assert property ($changed(PORT_CLK_EN) |-> $past(S_AXI_BVALID)
    || $past(SLEEP_MODE) != $past(SLEEP_MODE, 2)
    || $past(DEEP_SLEEP_MODE) != $past(DEEP_SLEEP_MODE, 2))
    else $error("enable changed without cause");
  upper_zero_a: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:10] == 22'h000000)
    else $error("upper read bits set");
  read_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> $stable(S_AXI_RDATA))
    else $error("read data moved");
  irq_cause_a: assert property ($rose(IRQ) |-> $past(PORT_ACC_FAULT)
    || $past(PORT_ACC_FAULT, 2) || $past(S_AXI_BVALID))
    else $error("interrupt without fault");
endmodule
bind dspg_top dspg_top_assertions #(.NPORT(NPORT)) chk (.CLK, .SRST, .S_AXI_BVALID,
  .S_AXI_RVALID, .S_AXI_RREADY, .S_AXI_RDATA, .SLEEP_MODE, .DEEP_SLEEP_MODE, .PORT_CLK_EN,
  .PORT_ACC_VALID, .PORT_ACC_PORT, .PORT_ACC_DONE, .PORT_ACC_FAULT, .IRQ);
`default_nettype wire

// >>> dv/deep_sleep_port_clock_gating_bench.sv
`timescale 1ns/1ps
`default_nettype none
module deep_sleep_port_clock_gating_bench;
  import dspg_pkg::*;
  logic clk, srst, awv, awr, wv, wrdy, bv, br, arv, arr, rv, rr, slp, dsl, av, dn, flt, irq;
  logic [11:0] awa, ara;
  logic [31:0] wd, rd;
  logic [1:0] brs, rrs;
  logic [3:0] ws;
  logic [7:0] en;
  logic [2:0] ap;
  int err_total, total_checks;
  dspg_top uut (.CLK(clk), .SRST(srst), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
    .S_AXI_AWADDR(awa), .S_AXI_AWPROT(3'h0), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy),
    .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws), .S_AXI_BVALID(bv), .S_AXI_BREADY(br),
    .S_AXI_BRESP(brs), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_ARADDR(ara),
    .S_AXI_ARPROT(3'h0), .S_AXI_RVALID(rv), .S_AXI_RREADY(rr), .S_AXI_RDATA(rd),
    .S_AXI_RRESP(rrs), .SLEEP_MODE(slp), .DEEP_SLEEP_MODE(dsl), .PORT_CLK_EN(en),
    .PORT_ACC_VALID(av), .PORT_ACC_PORT(ap), .PORT_ACC_DONE(dn), .PORT_ACC_FAULT(flt),
    .IRQ(irq));
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // ====================
  // shared tasks
  task final_report;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e);
    logic ad, dd;
    ad = 1'b0;
    dd = 1'b0;
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    while (!(ad && dd))
    begin
      @(posedge clk);
      if (awr && !ad)
      begin
        ad = 1'b1;
        awv <= 1'b0;
      end
      if (wrdy && !dd)
      begin
        dd = 1'b1;
        wv <= 1'b0;
      end
    end
    br <= 1'b1;
    while (!bv) @(posedge clk);
    br <= 1'b0;
    chk(brs, e);
  endtask
  task rdc(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    ara <= a;
    arv <= 1'b1;
    @(posedge clk);
    while (!arr) @(posedge clk);
    arv <= 1'b0;
    rr <= 1'b1;
    while (!rv) @(posedge clk);
    rr <= 1'b0;
    chk(rd, e);
    chk(rrs, er);
  endtask
  task acc(input logic [2:0] p, input logic e);
    ap <= p;
    av <= 1'b1;
    @(posedge clk);
    av <= 1'b0;
    @(posedge clk);
    chk(dn, 1);
    chk(flt, e);
  endtask
  task settle;
    repeat (3) @(posedge clk);
  endtask
  // ====================
  // scenarios
  task t_reset;
    chk(en, 0);
    rdc(OFS_DEEP_GATE, 0, RESP_OKAY);
    acc(3'h0, 1'b1);
  endtask
  task t_bits;
    for (int i = 0; i < 8; i++)
    begin
      wr(OFS_DEEP_GATE, 32'h1 << i, RESP_OKAY);
      rdc(OFS_DEEP_GATE, 32'h1 << i, RESP_OKAY);
    end
    wr(OFS_DEEP_GATE, 32'hffffff5a, RESP_OKAY);
    rdc(OFS_DEEP_GATE, 32'h5a, RESP_OKAY);
    ws <= 4'he;
    wr(OFS_DEEP_GATE, 32'h0, RESP_OKAY);
    ws <= 4'hf;
    rdc(OFS_DEEP_GATE, 32'h5a, RESP_OKAY);
  endtask
  task t_modes;
    wr(OFS_RUN_GATE, 32'h0f, RESP_OKAY);
    dsl <= 1'b1;
    settle;
    chk(en, 8'h0f);
    wr(OFS_RUN_CFG, 32'h1, RESP_OKAY);
    settle;
    chk(en, 8'h5a);
    for (int i = 0; i < 8; i++)
      acc(i[2:0], !(8'h5a >> i & 8'h01));
    dsl <= 1'b0;
    slp <= 1'b1;
    settle;
    chk(en, 8'h00);
    wr(OFS_SLEEP_GATE, 32'h33, RESP_OKAY);
    settle;
    chk(en, 8'h33);
    rdc(OFS_CLK_STATE, 32'h133, RESP_OKAY);
    dsl <= 1'b1;
    settle;
    chk(en, 8'h5a);
    dsl <= 1'b0;
    slp <= 1'b0;
    settle;
    chk(en, 8'h0f);
  endtask
  task t_irq;
    chk(irq, 0);
    wr(OFS_INT_MASK, 32'hff, RESP_OKAY);
    acc(3'h4, 1'b1);
    settle;
    chk(irq, 1);
    rdc(OFS_INT_STATUS, 32'hb5, RESP_OKAY);
    settle;
    chk(irq, 0);
    wr(12'hffc, 32'h0, RESP_SLVERR);
    rdc(12'hffc, 32'h0, RESP_SLVERR);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    settle;
    chk(en, 0);
    rdc(OFS_DEEP_GATE, 0, RESP_OKAY);
  endtask
  initial
  begin
    {srst, awv, wv, br, arv, rr, slp, dsl, av} = 9'h001 << 8;
    {awa, ara, wd, ap} = 59'h0;
    ws = 4'hf;
    err_total = 0;
    total_checks = 0;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    t_reset;
    t_bits;
    t_modes;
    t_irq;
    final_report;
  end
  // hang guard, well over ten times the expected run
  initial
  begin
    repeat (5000) @(posedge clk);
    err_total++;
    final_report;
  end
endmodule
`default_nettype wire
